// *** bench/load_cell_panel.sv ***
// Model of the load cell converter and the front panel keys.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module load_cell_panel
  import wcu_pkg::*;
(
  input wire logic clk_sys,
  output logic signed [W-1:0] sample,
  output logic sample_valid,
  output logic [4:0] keys,
  output logic tare_pin_n
);
  // Idle: no strobe, keys released, tare pin open
  initial
  begin
    sample = '0;
    sample_valid = 1'b0;
    keys = 5'h00;
    tare_pin_n = 1'b1;
  end
  // One conversion per call, nine cycles apart
  task automatic put(input int x);
    @(negedge clk_sys);
    sample = W'(x);
    sample_valid = 1'b1;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    sample = ~sample; // Stale data is not held
    repeat (7) @(negedge clk_sys);
  endtask
  // Keys and pin held n cycles; a shorted pin reads low
  task automatic hold(input logic [5:0] m, input int n);
    @(negedge clk_sys);
    keys = m[4:0];
    tare_pin_n = ~m[5];
    repeat (n) @(negedge clk_sys);
  endtask
endmodule

// *** bench/weight_conditioning_unit_props.sv ***
// Port-level checks on the weight conditioning unit.
// Assumes one clock, clk_sys, and the asynchronous active-low reset nrst.
`timescale 1ns/1ps
module weight_conditioning_unit_props
  import wcu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic signed [W-1:0] sample,
  input wire logic sample_valid,
  input wire logic [7:0] avg_len,
  input wire logic extra_filter_en,
  input wire logic checker_mode,
  input wire logic [6:0] motion_range,
  input wire logic [15:0] scale_division,
  input wire logic [16:0] preset_tare,
  input wire logic [16:0] capacity,
  input wire logic key_gn_en,
  input wire logic key_gn,
  input wire logic key_zero_clear,
  input wire logic signed [W-1:0] display_weight,
  input wire logic display_strobe,
  input wire logic signed [W-1:0] tare_weight,
  input wire logic settled,
  input wire logic net_lamp,
  input wire logic tare_lamp,
  input wire logic zero_limit_alarm,
  input wire logic preset_rejected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic signed [W-1:0] last;
  logic [7:0] run;
  int d;
  int lim;
  // Jump size against the motion range; raw samples only mean much with averaging off
  assign d = int'(sample) - int'(last);
  assign lim = int'(motion_range) * int'(scale_division);
  // Count of equal samples in a row, saturating
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      last <= '0;
      run <= 8'h00;
    end
    else if (sample_valid)
    begin
      last <= sample;
      run <= (sample != last) ? 8'h00 : ((run == 8'hff) ? run : run + 8'h01);
    end
  end
  AST_RESET: assert property ($rose(nrst) |=> !net_lamp && !tare_lamp && tare_weight == 0)
    else $error("outputs not idle after reset");
  AST_STROBE: assert property (display_strobe |=> !display_strobe)
    else $error("display strobe longer than one cycle");
  AST_DISP: assert property ($changed(display_weight) |-> display_strobe || $past(display_strobe))
    else $error("display moved without a strobe");
  AST_NET: assert property ($changed(net_lamp) |->
    key_gn_en && ($past(key_gn, 2) || $past(key_gn, 3) || $past(key_gn, 4)))
    else $error("net lamp moved without an enabled key");
  AST_TLAMP: assert property ($stable(tare_weight)[*3] |-> tare_lamp == (tare_weight != 0))
    else $error("tare lamp disagrees with tare");
  AST_ALARM: assert property ($fell(zero_limit_alarm) |->
    $past(key_zero_clear, 2) || $past(key_zero_clear, 3) || $past(key_zero_clear, 4))
    else $error("alarm cleared without zero clear");
  AST_PRESET: assert property (($stable(preset_tare) && $stable(scale_division))[*3] |->
    preset_rejected == (preset_tare > capacity || preset_tare < scale_division))
    else $error("preset check wrong");
  AST_MOTION: assert property (sample_valid && checker_mode && avg_len == 8'h01 &&
    !extra_filter_en && run > 8'h1e && (d > lim || -d > lim) |-> ##[1:12] !settled)
    else $error("settled kept after a jump");
  COV_SETTLED: cover property ($rose(settled));
  COV_ALARM: cover property ($rose(zero_limit_alarm));
  COV_NET: cover property ($rose(net_lamp));
endmodule
bind weight_conditioning_unit weight_conditioning_unit_props chk (.clk_sys, .nrst, .sample,
  .sample_valid, .avg_len, .extra_filter_en, .checker_mode, .motion_range, .scale_division,
  .preset_tare, .capacity, .key_gn_en, .key_gn, .key_zero_clear, .display_weight,
  .display_strobe, .tare_weight, .settled, .net_lamp, .tare_lamp, .zero_limit_alarm,
  .preset_rejected);

// *** bench/weight_conditioning_unit_test.sv ***
// Self-checking bench with a reference of gross, tare, lamps and display.
// Assumes the package, the unit and the load cell model are compiled first.
`timescale 1ns/1ps
module weight_conditioning_unit_test;
  import wcu_pkg::*;
  localparam int PT[4] = '{0, 500, 50001, 500};
  localparam int DV[4] = '{1, 1, 1, 600};
  localparam int RJ[4] = '{1, 0, 1, 1};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic signed [W-1:0] sample, display_weight, gross_weight, tare_weight;
  logic sample_valid, tare_pin_n, display_strobe, settled, net_lamp, tare_lamp;
  logic zero_limit_alarm, preset_rejected;
  logic [4:0] keys;
  logic [1:0] disp_rate_sel = 2'h0;
  logic [7:0] avg_len = 8'h02;
  logic extra_filter_en = 1'b0;
  logic checker_mode = 1'b0;
  logic preset_tare_en = 1'b0;
  logic key_zero_en = 1'b1;
  logic key_tare_en = 1'b1;
  logic key_gn_en = 1'b1;
  logic [6:0] motion_period = 7'h01;
  logic [6:0] motion_range = 7'h02;
  logic [15:0] scale_division = 16'h0001;
  logic [13:0] zero_limit = 14'h03e8;
  logic [6:0] track_period = 7'h01;
  logic [13:0] track_range = 14'h0000;
  logic [16:0] preset_tare = 17'h001f4;
  int err_total = 0;
  int samples_checked = 0;
  // Reference: last sample, zero offset, one-touch tare, display mode, alarm
  int v = 0;
  int zoff = 0;
  int otare = 0;
  bit net = 1'b0;
  bit alarm = 1'b0;
  load_cell_panel lc (.clk_sys, .sample, .sample_valid, .keys, .tare_pin_n);
  weight_conditioning_unit #(.TENTH(20), .STAB_LAG(8'h10)) uut (.clk_sys, .nrst, .sample,
    .sample_valid, .disp_rate_sel, .avg_len, .extra_filter_en, .checker_mode, .motion_period,
    .motion_range, .scale_division, .track_period, .track_range, .zero_limit,
    .preset_tare, .preset_tare_en, .capacity(17'h0c350), .key_zero_en, .key_tare_en,
    .key_gn_en, .key_zero(keys[0]), .key_zero_clear(keys[1]), .key_gn(keys[2]),
    .key_tare(keys[3]), .key_print(keys[4]), .tare_pin_n, .display_weight, .display_strobe,
    .gross_weight, .tare_weight, .settled, .net_lamp, .tare_lamp, .zero_limit_alarm,
    .preset_rejected);
  always #10 clk_sys = ~clk_sys;
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic step(input int x);
    v = x;
    lc.put(x);
  endtask
  // A short press then release; key edges act a few cycles late
  task automatic press(input logic [5:0] m);
    lc.hold(m, 4);
    lc.hold(6'h00, 6);
  endtask
  // Compare gross, tare, both lamps and the alarm with the reference, then the next display frame
  task automatic compare();
    int g;
    int t;
    int n;
    g = v - zoff;
    t = otare + (preset_tare_en ? int'(preset_tare) : 0);
    disp_rate_sel = 2'($urandom % 4);
    check(gross_weight, W'(g));
    check(tare_weight, W'(t));
    check(tare_lamp, t != 0);
    check(net_lamp, net);
    check(zero_limit_alarm, alarm);
    n = 0;
    while (display_strobe !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 3000)
    begin
      err_total++;
      stop_test();
    end
    @(posedge clk_sys);
    #1;
    check(display_weight, W'(net ? g - t : g));
    @(negedge clk_sys);
  endtask
  initial
  begin
    v = $urandom(44);
    repeat (12) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    step(1000);
    step(3000);
    check(gross_weight, W'(2000));
    avg_len = 8'h01;
    for (int i = 0; i < 6; i++)
      step(100 + $urandom % 4000);
    compare();
    $display("averaging done");
    step(300);
    press(6'h01);
    zoff = 300;
    step(300);
    compare();
    step(2000);
    press(6'h01);
    zoff = 1000;
    alarm = 1'b1;
    step(2000);
    compare();
    key_zero_en = 1'b0;
    step(2500);
    press(6'h01);
    step(2500);
    compare();
    key_zero_en = 1'b1;
    press(6'h02);
    zoff = 0;
    alarm = 1'b0;
    step(2000);
    compare();
    $display("zero done");
    key_gn_en = 1'b0;
    press(6'h04);
    compare();
    key_gn_en = 1'b1;
    press(6'h04);
    net = 1'b1;
    step(1234);
    press(6'h08);
    otare = 1234;
    step(1500);
    compare();
    lc.hold(6'h08, 6);
    lc.hold(6'h18, 6);
    lc.hold(6'h00, 6);
    otare = 0;
    compare();
    key_tare_en = 1'b0;
    press(6'h08);
    press(6'h20);
    otare = 1500;
    step(1700);
    compare();
    key_tare_en = 1'b1;
    preset_tare_en = 1'b1;
    step(1800);
    compare();
    press(6'h08);
    otare = 1300;
    step(2100);
    compare();
    $display("tare done");
    for (int i = 0; i < 4; i++)
    begin
      preset_tare = 17'(PT[i]);
      scale_division = 16'(DV[i]);
      repeat (4) @(negedge clk_sys);
      check(preset_rejected, RJ[i] != 0);
    end
    preset_tare = 17'h001f4;
    scale_division = 16'h0001;
    press(6'h04);
    net = 1'b0;
    compare();
    $display("preset done");
    for (int m = 0; m < 2; m++)
    begin
      checker_mode = m[0];
      extra_filter_en = ~m[0];
      for (int i = 0; i < 90; i++)
        step(2200);
      check(settled, 1'b1);
      step(2216);
      check(gross_weight, W'(m[0] ? 2216 : 2202));
      repeat (8) @(negedge clk_sys);
      check(settled, 1'b0);
    end
    extra_filter_en = 1'b0;
    step(2250);
    compare();
    $display("motion done");
    // A small settled offset is pulled back to zero by tracking
    track_range = 14'h0005;
    for (int i = 0; i < 45; i++)
      step(3);
    zoff = 3;
    check(settled, 1'b1);
    compare();
    $display("tracking done");
    stop_test();
  end
endmodule

// *** common/hist_if.sv ***
// Carrier between the conditioning core and its sample history memory.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface hist_if #(parameter int AW = 8, parameter int DW = 24);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** common/wcu_pkg.sv ***
// Shared constants and types for the weight conditioning unit.
// Assumes a 50 MHz system clock and a single asynchronous active-low reset.
package wcu_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int W = 24;                       // Weight sample width
  localparam int DISP_RATE_0 = 25;             // Display updates per second
  localparam int DISP_RATE_1 = 13;
  localparam int DISP_RATE_2 = 6;
  localparam int DISP_RATE_3 = 3;
  localparam int AVG_MAX = 128;                // Longest moving average
  localparam int AVG_LOG = 7;
  localparam int HIST_DEPTH = 512;             // Holds five one-second lags of history
  localparam int HIST_AW = 9;
  localparam int TENTH_HZ = 10;                // Tenths of a second per second
  localparam int TENTH_CYC = CLK_HZ / TENTH_HZ;
  localparam int PERIOD_MAX = 99;              // 9.9 s in tenths
  localparam int MRANGE_MAX = 99;
  localparam int ZLIM_MAX = 9999;
  localparam int ZTR_MAX = 9999;
  localparam int PTARE_MAX = 99999;
  localparam logic [7:0] STAB_LAG_DEF = 8'h64; // Samples per second, stable method
  localparam logic [7:0] CHK_LAG_DEF = 8'h09;  // Samples per 0.09 s, checker method
  localparam logic [2:0] STAB_TERMS = 3'h5;
  localparam logic [2:0] CHK_TERMS = 3'h3;
  localparam logic [1:0] EXTRA_SHIFT = 2'h3;   // Extra filter: 1/8 blend
  typedef enum logic [1:0] {st_moving = 2'b00, st_judging = 2'b01, st_settled = 2'b11} stab_type;
endpackage

// *** logic/hist_mem.sv ***
// Sample history memory with registered read data.
// Assumes one write and one read per clock, same clock domain.
`timescale 1ns/1ps
module hist_mem
  import wcu_pkg::*;
#(
  parameter int DEPTH = HIST_DEPTH
)
(
  input wire logic clk_sys,
  hist_if.mem bus
);
  logic [W-1:0] mem [DEPTH];

  // Write port; memory content needs no reset
  always_ff @(posedge clk_sys)
  begin
    if (bus.we)
    begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  // Registered read keeps this mappable to block RAM
  always_ff @(posedge clk_sys)
  begin
    bus.rdata <= mem[bus.raddr];
  end
endmodule

// *** logic/weight_conditioning_unit.sv ***
// Weight conditioning: averaging, motion check, zero, tare and gross/net.
// Assumes samples come from logic on clk_sys; keys and the tare pin are raw pins.
// How it works
// - Display refresh 25/13/6/3 per second only
// - Moving average of 1 to 128 samples
// - Extra filter only while settled, if enabled
// - Settled after range held for motion period
// - Mode picks stable or checker terms
// - Stable: five terms, first spans one second
// - Checker: three terms, first spans 0.09 s
// - Any term over range clears settled at once
// - Motion period 0.0 to 9.9 seconds
// - Motion range is setting times division
// - Zero tracking with period and range
// - Zero key zeroes gross, capped by limit
// - Alarm when zero moves beyond limit
// - Zero clear drops correction and alarm
// - Gross/net key toggles; net lamp follows
// - Net is gross minus tare
// - Tare key or pin captures tare
// - Print while tare held clears one-touch tare
// - Preset tare checked, used when enabled
// - One-touch and preset tare independent
// - Tare lamp lit when combined tare nonzero
// - Disabled panel keys are ignored, except tare held for print clear
`timescale 1ns/1ps
module weight_conditioning_unit
  import wcu_pkg::*;
#(
  parameter int TENTH = TENTH_CYC,
  parameter logic [7:0] STAB_LAG = STAB_LAG_DEF,
  parameter logic [7:0] CHK_LAG = CHK_LAG_DEF
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic signed [W-1:0] sample,
  input wire logic sample_valid,
  input wire logic [1:0] disp_rate_sel,
  input wire logic [7:0] avg_len,
  input wire logic extra_filter_en,
  input wire logic checker_mode,
  input wire logic [6:0] motion_period,
  input wire logic [6:0] motion_range,
  input wire logic [15:0] scale_division,
  input wire logic [6:0] track_period,
  input wire logic [13:0] track_range,
  input wire logic [13:0] zero_limit,
  input wire logic [16:0] preset_tare,
  input wire logic preset_tare_en,
  input wire logic [16:0] capacity,
  input wire logic key_zero_en,
  input wire logic key_tare_en,
  input wire logic key_gn_en,
  input wire logic key_zero,
  input wire logic key_zero_clear,
  input wire logic key_gn,
  input wire logic key_tare,
  input wire logic key_print,
  input wire logic tare_pin_n,
  output logic signed [W-1:0] display_weight,
  output logic display_strobe,
  output logic signed [W-1:0] gross_weight,
  output logic signed [W-1:0] tare_weight,
  output logic settled,
  output logic net_lamp,
  output logic tare_lamp,
  output logic zero_limit_alarm,
  output logic preset_rejected
);
  hist_if #(.AW(HIST_AW), .DW(W)) hb ();
  hist_mem #(.DEPTH(HIST_DEPTH)) u_hist (.clk_sys(clk_sys), .bus(hb));

  function automatic logic signed [W-1:0] absdiff(input logic signed [W-1:0] a,
                                                   input logic signed [W-1:0] b);
    logic signed [W-1:0] d;
    d = a - b;
    return (d < 0) ? -d : d;
  endfunction

  // Pin synchronisers; the first stage feeds only the second
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_d;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1 <= 6'h20;
      pin_s2 <= 6'h20;
      pin_d <= 6'h20;
    end
    else
    begin
      pin_s1 <= {tare_pin_n, key_print, key_tare, key_gn, key_zero_clear, key_zero};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  logic p_zero, p_clr, p_gn, p_tare, p_print, tare_held;
  assign p_zero = pin_s2[0] & ~pin_d[0] & key_zero_en;
  assign p_clr = pin_s2[1] & ~pin_d[1];
  assign p_gn = pin_s2[2] & ~pin_d[2] & key_gn_en;
  assign tare_held = pin_s2[3];
  assign p_print = pin_s2[4] & ~pin_d[4];
  // Pin shorted to common acts like a tare press, no key enable applies
  assign p_tare = (pin_s2[3] & ~pin_d[3] & key_tare_en & ~pin_s2[4])
                  | (~pin_s2[5] & pin_d[5]);

  // Moving average: running sum over a ring of the last avg_len samples
  logic signed [W-1:0] ring [AVG_MAX];
  logic [AVG_LOG-1:0] rptr;
  logic [AVG_LOG:0] fill;
  logic signed [W+AVG_LOG:0] acc;
  logic [7:0] len;
  assign len = (avg_len == 8'h00) ? 8'h01 : ((avg_len > 8'h80) ? 8'h80 : avg_len);
  logic signed [W-1:0] oldest;
  assign oldest = ring[AVG_LOG'(rptr - len[AVG_LOG-1:0])];
  always_ff @(posedge clk_sys)
  begin
    if (sample_valid)
    begin
      ring[rptr] <= sample;
    end
  end
  logic signed [W-1:0] avg;
  logic [7:0] len_q;
  logic step1;
  logic step2;
  // Sum on the sample edge, divide one cycle later, filter one after that
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rptr <= '0;
      fill <= '0;
      acc <= '0;
      avg <= '0;
      len_q <= 8'h00;
      step1 <= 1'b0;
      step2 <= 1'b0;
    end
    else
    begin
      step1 <= sample_valid;
      step2 <= step1;
      if (sample_valid)
      begin
        rptr <= rptr + 1'b1;
        len_q <= len;
        if (len != len_q)
        begin
          // A new length restarts the sum so it never holds a stale count
          fill <= {{AVG_LOG{1'b0}}, 1'b1};
          acc <= {{(AVG_LOG + 1){sample[W-1]}}, sample};
        end
        else if ({1'b0, fill} < {1'b0, len})
        begin
          fill <= fill + 1'b1;
          acc <= acc + sample;
        end
        else
        begin
          acc <= acc + sample - oldest;
        end
      end
      if (step1)
      begin
        avg <= W'(acc / $signed({1'b0, fill}));
      end
    end
  end

  // Extra smoothing only while settled
  logic signed [W-1:0] filt;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      filt <= '0;
    end
    else if (step2)
    begin
      if (extra_filter_en && settled)
      begin
        filt <= filt + ((avg - filt) >>> EXTRA_SHIFT);
      end
      else
      begin
        filt <= avg;
      end
    end
  end

  // Motion check: terms read lags of 1..nterms base spans (5 stable, 3 checker) from the history memory
  logic [HIST_AW-1:0] wptr;
  logic [2:0] term;
  logic [2:0] nterms;
  logic [7:0] lag;
  logic scan, rd_pend, over;
  logic signed [W-1:0] cur;
  logic [W-1:0] range_w;
  assign nterms = checker_mode ? CHK_TERMS : STAB_TERMS;
  assign lag = checker_mode ? CHK_LAG : STAB_LAG;
  assign range_w = W'(motion_range * scale_division);
  assign hb.we = sample_valid;
  assign hb.waddr = wptr;
  assign hb.wdata = sample;
  assign hb.raddr = HIST_AW'(wptr - HIST_AW'(term * lag) - 1'b1); // Newest is at wptr - 1
  stab_type stab;
  logic [23:0] tick;
  logic tenth;
  logic [6:0] held;
  assign tenth = (tick == 24'(TENTH - 1));
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tick <= '0;
    end
    else
    begin
      tick <= tenth ? '0 : tick + 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr <= '0;
      term <= '0;
      scan <= 1'b0;
      rd_pend <= 1'b0;
      over <= 1'b0;
      cur <= '0;
    end
    else if (sample_valid)
    begin
      wptr <= wptr + 1'b1;
      cur <= sample;
      term <= 3'h1;
      scan <= 1'b1;
      rd_pend <= 1'b0;
      over <= 1'b0;
    end
    else if (scan)
    begin
      // One read issued per cycle, data one cycle later, so five terms fit between samples
      rd_pend <= (term <= nterms);
      if (term <= nterms)
      begin
        term <= term + 1'b1;
      end
      if (rd_pend)
      begin
        over <= over | (absdiff(cur, hb.rdata) > $signed(range_w));
        if (term > nterms)
        begin
          scan <= 1'b0;
        end
      end
    end
  end
  // Scan done one cycle after last read; settled drops one cycle after that
  logic scan_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      scan_q <= 1'b0;
      stab <= st_moving;
      held <= '0;
      settled <= 1'b0;
    end
    else
    begin
      scan_q <= scan;
      case (stab)
        st_moving:
        begin
          held <= '0;
          if (scan_q && !scan && !over)
          begin
            stab <= st_judging;
          end
        end
        st_judging:
        begin
          if (scan_q && !scan && over)
          begin
            stab <= st_moving;
          end
          else if (held >= motion_period)
          begin
            stab <= st_settled;
            settled <= 1'b1;
          end
          else if (tenth)
          begin
            held <= held + 1'b1;
          end
        end
        st_settled:
        begin
          if (scan_q && !scan && over)
          begin
            stab <= st_moving;
            settled <= 1'b0;
          end
        end
        default:
        begin
          stab <= st_moving;
          settled <= 1'b0;
        end
      endcase
    end
  end

  // Zero point: manual offset plus tracking, bounded by the limit
  logic signed [W-1:0] manual_zero_offset;
  logic signed [W-1:0] raw_gross;
  logic [6:0] zt_cnt;
  logic signed [W-1:0] lim;
  assign lim = W'(zero_limit);
  assign raw_gross = filt - manual_zero_offset;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      manual_zero_offset <= '0;
      zero_limit_alarm <= 1'b0;
      zt_cnt <= '0;
    end
    else if (p_clr)
    begin
      manual_zero_offset <= '0;
      zero_limit_alarm <= 1'b0;
      zt_cnt <= '0;
    end
    else if (p_zero)
    begin
      if (absdiff(filt, '0) > lim)
      begin
        manual_zero_offset <= (filt < 0) ? -lim : lim;
        zero_limit_alarm <= 1'b1;
      end
      else
      begin
        manual_zero_offset <= filt;
      end
    end
    else if (tenth)
    begin
      // Tracking only nudges a small, settled gross back to zero
      if (settled && raw_gross != 0 && absdiff(raw_gross, '0) <= $signed(W'(track_range)))
      begin
        if (zt_cnt >= track_period)
        begin
          zt_cnt <= '0;
          if (absdiff(filt, '0) > lim)
          begin
            zero_limit_alarm <= 1'b1;
          end
          else
          begin
            manual_zero_offset <= filt;
          end
        end
        else
        begin
          zt_cnt <= zt_cnt + 1'b1;
        end
      end
      else
      begin
        zt_cnt <= '0;
      end
    end
  end

  // Tare sources and gross/net selection
  logic signed [W-1:0] onetouch;
  logic signed [W-1:0] preset;
  logic net_sel;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      onetouch <= '0;
      net_sel <= 1'b0;
      preset <= '0;
      preset_rejected <= 1'b0;
    end
    else
    begin
      if (p_print && tare_held)
      begin
        onetouch <= '0;
      end
      else if (p_tare)
      begin
        onetouch <= raw_gross - preset;
      end
      if (p_gn)
      begin
        net_sel <= ~net_sel;
      end
      // Out-of-range preset is refused; the last good value stays
      if (preset_tare > capacity || preset_tare < 17'(scale_division)
          || preset_tare > 17'(PTARE_MAX))
      begin
        preset_rejected <= 1'b1;
      end
      else
      begin
        preset_rejected <= 1'b0;
        preset <= preset_tare_en ? W'(preset_tare) : '0;
      end
    end
  end

  // Display refresh divider, independent of sample processing; built on the tenth
  // tick's idea of a second so a shortened tick scales the refresh with it
  logic [23:0] dcnt;
  logic [23:0] dlim;
  assign dlim = 24'((TENTH * TENTH_HZ) / ((disp_rate_sel == 2'h0) ? DISP_RATE_0 :
                (disp_rate_sel == 2'h1) ? DISP_RATE_1 :
                (disp_rate_sel == 2'h2) ? DISP_RATE_2 : DISP_RATE_3));
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      dcnt <= '0;
      display_strobe <= 1'b0;
      display_weight <= '0;
      gross_weight <= '0;
      tare_weight <= '0;
      net_lamp <= 1'b0;
      tare_lamp <= 1'b0;
    end
    else
    begin
      gross_weight <= raw_gross;
      tare_weight <= onetouch + preset;
      tare_lamp <= (onetouch + preset) != 0;
      net_lamp <= net_sel;
      display_strobe <= (dcnt >= dlim - 1'b1);
      if (dcnt >= dlim - 1'b1)
      begin
        dcnt <= '0;
        display_weight <= net_sel ? raw_gross - onetouch - preset : raw_gross;
      end
      else
      begin
        dcnt <= dcnt + 1'b1;
      end
    end
  end
endmodule
